//--- src/gcrb_pkg.sv
// Purpose: Constants for the global configuration register bank
// Assumes: Byte-wide index/data port access
// Notes: Indices are the full 8-bit index port values
package gcrb_pkg;
	localparam logic [7:0] IDX_SOFT_RESET = 8'h02;
	localparam logic [7:0] IDX_RUN_SELECT = 8'h03;
	localparam logic [7:0] IDX_UNIT_SELECT = 8'h07;
	localparam logic [7:0] IDX_GLOBAL_LAST = 8'h2f;
	localparam logic [7:0] RST_INDEX = 8'h00;
	localparam logic [7:0] RST_SOFT_RESET = 8'h00;
	localparam logic [7:0] RST_RUN_SELECT = 8'h03;
	localparam logic [7:0] RST_UNIT_SELECT = 8'h00;
	localparam logic [7:0] RUN_SELECT_MASK = 8'h83;
	localparam int BIT_SOFT_RESET = 0;
	localparam int BIT_RUN_ACCESS = 7;
	localparam logic [15:0] RUN_ADDR_SEL00 = 16'h00e0;
	localparam logic [15:0] RUN_ADDR_SEL01 = 16'h00e2;
	localparam logic [15:0] RUN_ADDR_SEL10 = 16'h00e4;
	localparam logic [15:0] RUN_ADDR_SEL11 = 16'h00ea;
	localparam int UNIT_COUNT = 16;
	localparam int UNIT_BITS = 4;
endpackage

//--- src/gcrb_unit_flags.sv
// Purpose: Activate flag store, one bit per logical device unit
// Assumes: Single writer per cycle
// Notes: Read data comes from a register
`timescale 1ns/1ns
module gcrb_unit_flags
	import gcrb_pkg::*;
#(
	parameter int COUNT = UNIT_COUNT,
	parameter int ABITS = UNIT_BITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clear_all,
	input wire logic wr_en,
	input wire logic [ABITS-1:0] addr,
	input wire logic wr_data,
	output logic rd_data,
	output logic [COUNT-1:0] flags
);
	if (COUNT > (1 << ABITS) || COUNT < 1) begin : g_bad_count
		$error("gcrb_unit_flags: COUNT does not fit ABITS");
	end

	logic [COUNT-1:0] next_flags;
	logic next_rd_data;

	always_comb begin
		next_flags = flags;
		if (clear_all) begin
			next_flags = '0;
		end else if (wr_en && (int'(addr) < COUNT)) begin
			next_flags[addr] = wr_data;
		end
		next_rd_data = (int'(addr) < COUNT) ? next_flags[addr] : 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags <= '0;
			rd_data <= 1'b0;
		end else begin
			flags <= next_flags;
			rd_data <= next_rd_data;
		end
	end
endmodule // gcrb_unit_flags

//--- src/gcrb_bank.sv
// Purpose: Chip-level global configuration registers behind index and data ports
// Assumes: Host strobes are one-cycle pulses synchronous to clk
// Notes: Read data is registered; it appears the cycle after the read strobe
//
// Operation
// - Global registers live only at index values 0x00 through 0x2f.
// - All eight index bits are decoded so no two index values alias.
// - Unimplemented indices and bits drop writes and read back zero.
// - The index port is written first and data port accesses then hit that register.
// - Global registers are reachable only in configuration mode.
// - Writing one to bit 0 at index 0x02 pulses a soft reset and the bit self-clears.
// - Soft reset loads registers that own a soft reset value and leaves the rest.
// - Bit 7 at index 0x03 opens the run-mode general-purpose group access.
// - Bits 1:0 at index 0x03 pick the run-mode select address 0xe0/0xe2/0xe4/0xea.
// - A write at index 0x07 picks the logical unit that later accesses reach.
// - An activate command touches only the currently selected unit.
`timescale 1ns/1ns
module gcrb_bank
	import gcrb_pkg::*;
#(
	parameter int UNITS = UNIT_COUNT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic config_mode,
	input wire logic index_wr,
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic [7:0] wr_data,
	input wire logic activate_wr,
	input wire logic activate_value,
	output logic [7:0] rd_data,
	output logic [7:0] index,
	output logic soft_reset,
	output logic run_access_en,
	output logic [15:0] run_select_addr,
	output logic [7:0] device_unit_select,
	output logic [UNITS-1:0] unit_active,
	output logic unit_active_rd
);
	if (UNITS < 1 || UNITS > UNIT_COUNT) begin : g_bad_units
		$error("gcrb_bank: UNITS out of range");
	end

	function automatic logic [15:0] run_addr(input logic [1:0] sel);
		unique case (sel)
			2'b00: run_addr = RUN_ADDR_SEL00;
			2'b01: run_addr = RUN_ADDR_SEL01;
			2'b10: run_addr = RUN_ADDR_SEL10;
			2'b11: run_addr = RUN_ADDR_SEL11;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic [7:0] run_select;
	logic [7:0] next_index;
	logic [7:0] next_run_select;
	logic [7:0] next_unit_select;
	logic next_soft_reset;
	logic [7:0] next_rd_data;
	logic [15:0] next_run_select_addr;
	logic in_global;
	logic hit_soft;
	logic hit_run;
	logic hit_unit;

	always_comb begin
		in_global = (index <= IDX_GLOBAL_LAST);
		hit_soft = config_mode && (index == IDX_SOFT_RESET);
		hit_run = config_mode && (index == IDX_RUN_SELECT);
		hit_unit = config_mode && (index == IDX_UNIT_SELECT);
		next_index = index_wr ? wr_data : index;
		next_run_select = run_select;
		next_unit_select = device_unit_select;
		next_soft_reset = 1'b0;
		if (data_wr && hit_soft) begin
			next_soft_reset = wr_data[BIT_SOFT_RESET];
		end
		if (data_wr && hit_run) begin
			next_run_select = wr_data & RUN_SELECT_MASK;
		end
		if (data_wr && hit_unit) begin
			next_unit_select = wr_data;
		end
		// Soft reset has no effect here: none of these registers owns a soft value
		next_rd_data = 8'h00;
		if (data_rd && config_mode && in_global) begin
			if (index == IDX_RUN_SELECT) begin
				next_rd_data = run_select;
			end else if (index == IDX_UNIT_SELECT) begin
				next_rd_data = device_unit_select;
			end
		end
		next_run_select_addr = run_addr(next_run_select[1:0]);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			index <= RST_INDEX;
			run_select <= RST_RUN_SELECT;
			device_unit_select <= RST_UNIT_SELECT;
			soft_reset <= RST_SOFT_RESET[BIT_SOFT_RESET];
			rd_data <= 8'h00;
			run_access_en <= RST_RUN_SELECT[BIT_RUN_ACCESS];
			run_select_addr <= RUN_ADDR_SEL11;
		end else begin
			index <= next_index;
			run_select <= next_run_select;
			device_unit_select <= next_unit_select;
			soft_reset <= next_soft_reset;
			rd_data <= next_rd_data;
			run_access_en <= next_run_select[BIT_RUN_ACCESS];
			run_select_addr <= next_run_select_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-unit activate flags

	logic act_en;

	always_comb begin
		act_en = activate_wr && config_mode;
	end

	gcrb_unit_flags #(
		.COUNT(UNITS),
		.ABITS(UNIT_BITS)
	) gcrb_unit_flags_i (
		.clk(clk),
		.rst_b(rst_b),
		.clear_all(soft_reset),
		.wr_en(act_en),
		.addr(device_unit_select[UNIT_BITS-1:0]),
		.wr_data(activate_value),
		.rd_data(unit_active_rd),
		.flags(unit_active)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	unit_select_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && config_mode && index == IDX_UNIT_SELECT)
		|=> device_unit_select == $past(wr_data))
		else $error("unit select not loaded");

	soft_reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		soft_reset |=> !soft_reset || $past(data_wr && index == IDX_SOFT_RESET))
		else $error("soft reset did not self clear");

	config_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!config_mode && !index_wr) |=> $stable(device_unit_select) && $stable(run_access_en))
		else $error("register changed outside configuration mode");

	reserved_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_rd && (index != IDX_RUN_SELECT) && (index != IDX_UNIT_SELECT))
		|=> rd_data == 8'h00)
		else $error("reserved index read nonzero");

	run_addr_map_a: assert property (@(posedge clk) disable iff (!rst_b)
		run_select_addr == ((run_select[1:0] == 2'b11) ? RUN_ADDR_SEL11 :
		(run_select[1:0] == 2'b10) ? RUN_ADDR_SEL10 :
		(run_select[1:0] == 2'b01) ? RUN_ADDR_SEL01 : RUN_ADDR_SEL00))
		else $error("run select address mismatch");

	run_reserved_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && config_mode && index == IDX_RUN_SELECT)
		|=> (run_select[6:2] == 5'h00) && (run_access_en == $past(wr_data[7])))
		else $error("run select reserved bits or enable wrong");

	index_alias_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && index[7:3] != 5'h00) |=> $stable(device_unit_select) && $stable(run_select))
		else $error("aliased index wrote a register");

	unit_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_rd && config_mode && index == IDX_UNIT_SELECT)
		|=> rd_data == $past(device_unit_select))
		else $error("unit select read back wrong");

	activate_only_selected_a: assert property (@(posedge clk) disable iff (!rst_b)
		(act_en && !soft_reset) |=>
		((unit_active ^ $past(unit_active)) & ~(UNITS'(1) << $past(device_unit_select[UNIT_BITS-1:0])))
		== '0)
		else $error("activate touched another unit");

	activate_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		(act_en && !soft_reset && (int'(device_unit_select[UNIT_BITS-1:0]) < UNITS))
		|=> unit_active_rd == $past(activate_value))
		else $error("activate value not stored");

	activate_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!act_en && !soft_reset)
		|=> $stable(unit_active))
		else $error("unit flags changed without activate");

	mode_act_block_a: assert property (@(posedge clk) disable iff (!rst_b)
		(activate_wr && !config_mode && !soft_reset)
		|=> $stable(unit_active))
		else $error("activate taken outside configuration mode");

	unit_flag_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		(int'(device_unit_select[UNIT_BITS-1:0]) < UNITS)
		|=> unit_active_rd == unit_active[$past(device_unit_select[UNIT_BITS-1:0])])
		else $error("selected unit flag read wrong");

	////////////////////////////////////////////////////////////////////////////
	// Index and data port checks

	index_load_a: assert property (@(posedge clk) disable iff (!rst_b)
		index_wr
		|=> index == $past(wr_data))
		else $error("index not loaded");

	index_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!index_wr
		|=> $stable(index))
		else $error("index changed without index write");

	run_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_rd && config_mode && index == IDX_RUN_SELECT)
		|=> rd_data == $past(run_select))
		else $error("run select read back wrong");

	read_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		!data_rd
		|=> rd_data == 8'h00)
		else $error("read data not zero without read");

	mode_read_block_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_rd && !config_mode)
		|=> rd_data == 8'h00)
		else $error("read answered outside configuration mode");

	global_range_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && index > IDX_GLOBAL_LAST)
		|=> $stable(device_unit_select) && $stable(run_select) && !soft_reset)
		else $error("write above global range took effect");

	reserved_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && (index < IDX_SOFT_RESET || (index > IDX_RUN_SELECT && index < IDX_UNIT_SELECT)))
		|=> $stable(device_unit_select) && $stable(run_select) && !soft_reset)
		else $error("reserved index write took effect");

	full_decode_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && config_mode && index[2:0] == IDX_UNIT_SELECT[2:0] && index != IDX_UNIT_SELECT)
		|=> $stable(device_unit_select))
		else $error("partial index decode wrote unit select");

	unit_write_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(data_wr && config_mode && index == IDX_UNIT_SELECT)
		|=> $stable(device_unit_select))
		else $error("unit select changed without write");

	////////////////////////////////////////////////////////////////////////////
	// Run-mode select and soft reset checks

	run_write_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(data_wr && config_mode && index == IDX_RUN_SELECT)
		|=> $stable(run_select) && $stable(run_access_en))
		else $error("run select changed without write");

	run_enable_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && config_mode && index == IDX_RUN_SELECT)
		|=> run_access_en == $past(wr_data[BIT_RUN_ACCESS]))
		else $error("run access enable not loaded");

	soft_reset_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_wr && config_mode && index == IDX_SOFT_RESET && wr_data[BIT_SOFT_RESET])
		|=> soft_reset)
		else $error("soft reset not raised");

	soft_reset_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(data_wr && config_mode && index == IDX_SOFT_RESET && wr_data[BIT_SOFT_RESET])
		|=> !soft_reset)
		else $error("soft reset without command");

	soft_clear_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
		soft_reset
		|=> unit_active == '0)
		else $error("soft reset left unit flags set");

	soft_keep_regs_a: assert property (@(posedge clk) disable iff (!rst_b)
		(soft_reset && !data_wr)
		|=> $stable(device_unit_select) && $stable(run_select))
		else $error("soft reset changed a kept register");

	soft_no_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
		(data_rd && index == IDX_SOFT_RESET)
		|=> rd_data == 8'h00)
		else $error("soft reset command read back");

	////////////////////////////////////////////////////////////////////////////
	// Reset value checks

	reset_values_a: assert property (@(posedge clk)
		$rose(rst_b) |-> (index == RST_INDEX) && (run_select == RST_RUN_SELECT) &&
		(device_unit_select == RST_UNIT_SELECT) && (unit_active == '0) &&
		(soft_reset == RST_SOFT_RESET[BIT_SOFT_RESET]))
		else $error("register reset value wrong");

	reset_run_outputs_a: assert property (@(posedge clk)
		$rose(rst_b) |-> (run_select_addr == RUN_ADDR_SEL11) && (rd_data == 8'h00) &&
		(run_access_en == RST_RUN_SELECT[BIT_RUN_ACCESS]))
		else $error("run outputs reset value wrong");
endmodule // gcrb_bank

//--- testbench/gcrb_host.sv
// Purpose: Host model for index and data port cycles
// Assumes: One strobe at a time
// Notes: Idle data shows the inverse of the last value
`timescale 1ns/1ns
module gcrb_host (
	input wire logic clk,
	output logic index_wr,
	output logic data_wr,
	output logic data_rd,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	initial begin
		{index_wr, data_wr, data_rd} = 3'h0;
		wr_data = 8'h00;
	end
	// One strobe cycle of the kind given by k, then idle; read data is sampled 1 ns after the strobe drops
	task automatic cyc(input logic [2:0] k, input logic [7:0] v, output logic [7:0] q);
		@(posedge clk);
		{index_wr, data_wr, data_rd} <= k;
		wr_data <= v;
		@(posedge clk);
		{index_wr, data_wr, data_rd} <= 3'h0;
		wr_data <= ~v;
		#1;
		q = rd_data;
	endtask
endmodule // gcrb_host

//--- testbench/global_config_register_bank_bench.sv
// Purpose: Bench for the global configuration register bank
// Assumes: Host model drives the ports
// Notes: Mode and activate come from the bench
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module global_config_register_bank_bench;
	import gcrb_pkg::*;
	logic clk, rst_b, config_mode, index_wr, data_wr, data_rd, activate_wr, activate_value;
	logic [7:0] wr_data, rd_data, index, device_unit_select, q;
	logic soft_reset, run_access_en, unit_active_rd;
	logic [15:0] run_select_addr, unit_active;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	gcrb_host gcrb_host_i (.clk(clk), .index_wr(index_wr), .data_wr(data_wr),
		.data_rd(data_rd), .wr_data(wr_data), .rd_data(rd_data));
	gcrb_bank gcrb_bank_i (.clk(clk), .rst_b(rst_b), .config_mode(config_mode),
		.index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data),
		.activate_wr(activate_wr), .activate_value(activate_value), .rd_data(rd_data),
		.index(index), .soft_reset(soft_reset), .run_access_en(run_access_en),
		.run_select_addr(run_select_addr), .device_unit_select(device_unit_select),
		.unit_active(unit_active), .unit_active_rd(unit_active_rd));
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		gcrb_host_i.cyc(3'b100, a, q);
		gcrb_host_i.cyc(3'b010, v, q);
	endtask
	task automatic rd;
		gcrb_host_i.cyc(3'b001, 8'h00, q);
	endtask
	task automatic act(input logic v);
		@(posedge clk);
		activate_wr <= 1'b1;
		activate_value <= v;
		@(posedge clk);
		activate_wr <= 1'b0;
		#1;
	endtask
	task automatic t_runsel;
		logic [15:0] tbl[4] = '{16'h00e0, 16'h00e2, 16'h00e4, 16'h00ea};
		`CHK("addr0", 16'h00ea, run_select_addr)
		`CHK("idx0", 8'h00, index)
		`CHK("unit0", 8'h00, device_unit_select)
		`CHK("en0", 1'b0, run_access_en)
		for (int i = 0; i < 4; i++) begin
			wreg(8'h03, {i[0], 5'h1f, i[1:0]});
			`CHK("addr", tbl[i], run_select_addr)
			`CHK("en", i[0], run_access_en)
			rd;
			`CHK("rb3", {i[0], 5'h00, i[1:0]}, q)
		end
	endtask
	task automatic t_unit;
		wreg(8'h07, 8'h05);
		`CHK("unit", 8'h05, device_unit_select)
		act(1'b1);
		wreg(8'h07, 8'h03);
		act(1'b1);
		`CHK("act", 16'h0028, unit_active)
		rd;
		`CHK("rb7", 8'h03, q)
		`CHK("actrd", 1'b1, unit_active_rd)
		act(1'b0);
		`CHK("deact", 16'h0020, unit_active)
		`CHK("deactrd", 1'b0, unit_active_rd)
	endtask
	task automatic t_resv;
		logic [7:0] ix[7] = '{8'h00, 8'h01, 8'h04, 8'h06, 8'h2f, 8'h83, 8'h87};
		foreach (ix[k]) begin
			wreg(ix[k], 8'h40);
			rd;
			`CHK("resv", 8'h00, q)
			`CHK("idx", ix[k], index)
		end
		`CHK("keep3", 16'h00ea, run_select_addr)
		`CHK("keep7", 8'h03, device_unit_select)
	endtask
	task automatic t_mode;
		@(posedge clk);
		config_mode <= 1'b0;
		wreg(8'h07, 8'h09);
		act(1'b1);
		`CHK("blk", 8'h03, device_unit_select)
		`CHK("blka", 16'h0020, unit_active)
		rd;
		`CHK("blkr", 8'h00, q)
		@(posedge clk);
		config_mode <= 1'b1;
	endtask
	task automatic t_soft;
		wreg(8'h02, 8'h01);
		`CHK("sr", 1'b1, soft_reset)
		@(posedge clk);
		#1;
		`CHK("sr0", 1'b0, soft_reset)
		`CHK("clr", 16'h0000, unit_active)
		`CHK("kp", 16'h00ea, run_select_addr)
		`CHK("kp7", 8'h03, device_unit_select)
		rd;
		`CHK("rb2", 8'h00, q)
	endtask
	task automatic t_hard;
		wreg(8'h03, 8'h80);
		`CHK("pre", 16'h00e0, run_select_addr)
		wreg(8'h07, 8'h05);
		act(1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		`CHK("hidx", 8'h00, index)
		`CHK("hunit", 8'h00, device_unit_select)
		`CHK("haddr", 16'h00ea, run_select_addr)
		`CHK("hen", 1'b0, run_access_en)
		`CHK("hact", 16'h0000, unit_active)
		wreg(8'h07, 8'h02);
		`CHK("post", 8'h02, device_unit_select)
		rd;
		`CHK("postrd", 8'h02, q)
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_b, activate_wr, activate_value} = 3'h0;
		config_mode = 1'b1;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_runsel;
		t_unit;
		t_resv;
		t_mode;
		t_soft;
		t_hard;
		final_report;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			final_report;
		end
	end
endmodule // global_config_register_bank_bench
